// File: logic/mmd_map.svh
// Address map, reset values and table constants of the memory map decoder
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH

// Internal code/data RAM, 16 KB from address zero
`define MMD_RAM_LO        16'h0000
`define MMD_RAM_HI        16'h3fff
// Scratch RAM, 0.5 KB
`define MMD_SCR_LO        16'he000
`define MMD_SCR_HI        16'he1ff
// Waveform descriptor memory, 128 bytes
`define MMD_WAVE_LO       16'he400
`define MMD_WAVE_HI       16'he47f
// Core-addressable control register window, 512 bytes
`define MMD_REG_LO        16'he500
`define MMD_REG_HI        16'he6ff
// Setup packet buffer, 8 bytes inside the register window
`define MMD_SETUP_LO      16'he6b8
`define MMD_SETUP_HI      16'he6bf
// Small endpoint buffers, 64 bytes each
`define MMD_CTRL_LO       16'he740
`define MMD_CTRL_HI       16'he77f
`define MMD_SOUT_LO       16'he780
`define MMD_SOUT_HI       16'he7bf
`define MMD_SIN_LO        16'he7c0
`define MMD_SIN_HI        16'he7ff
// Large endpoint buffers, 8 x 512 bytes
`define MMD_LARGE_LO      16'hf000
`define MMD_LARGE_HI      16'hffff
// Start of the on-chip data area that blocks external strobes
`define MMD_ONCHIP_LO     16'he000

// Packet limits of the large buffers
`define MMD_PKT_FS        10'h040
`define MMD_PKT_HS        10'h200
`define MMD_FS_OFS_LIM    9'h040

// Layout count, reset layout and reset endpoint-one type
`define MMD_LAYOUTS       4'hc
`define MMD_LAYOUT_RST    4'h0
`define MMD_TYPE_BULK     2'h2
`define MMD_TYPE_INT      2'h3
`define MMD_EP1_TYPE_RST  2'h2

// Layout table: per entry {ep2, ep4, ep6, ep8} buffer depths, 3 bits each
`define MMD_LAYOUT_TABLE  {12'h610, 12'h810, 12'h4a0, 12'h420, 12'h820, 12'h812, \
                           12'h612, 12'h618, 12'h410, 12'h490, 12'h412, 12'h492}

`endif

// File: logic/mmd_pkg.sv
// Types shared by the memory map decoder modules
package mmd_pkg;

	// Decoded target of an access
	typedef enum logic [3:0] {
		RG_NONE,
		RG_MAIN_RAM,
		RG_SCRATCH,
		RG_WAVE,
		RG_REGS,
		RG_SETUP,
		RG_CTRL_BUF,
		RG_SMALL_OUT,
		RG_SMALL_IN,
		RG_LARGE_BUF,
		RG_EXTERNAL,
		RG_RESERVED
	} mmd_region_type;

endpackage

// File: logic/mmd_setup_if.sv
// Link between the decoder and its setup packet store
`timescale 1ns/1ps
interface mmd_setup_if;
	logic       wr_en;
	logic [2:0] wr_idx;
	logic [7:0] wr_data;
	logic       rd_en;
	logic [2:0] rd_idx;
	logic [7:0] rd_data;

	modport host (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data);
	modport mem  (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data);
endinterface

// File: logic/mmd_setup_buf.sv
// Eight-byte setup packet store with registered read data
`timescale 1ns/1ps
module mmd_setup_buf (
	input  wire logic  i_clk,
	input  wire logic  i_rst_n,
	mmd_setup_if.mem   sif
);

	logic [7:0] byte_reg [8];
	logic [7:0] rd_data_reg;

	// One storage byte per setup packet position
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_byte
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					byte_reg[gi] <= 8'h00;
				end else if (sif.wr_en && (sif.wr_idx == 3'(gi))) begin
					byte_reg[gi] <= sif.wr_data;
				end
			end
		end
	endgenerate

	// Read port, data held until the next read
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_data_reg <= 8'h00;
		end else if (sif.rd_en) begin
			rd_data_reg <= byte_reg[sif.rd_idx];
		end
	end

	assign sif.rd_data = rd_data_reg;

endmodule // mmd_setup_buf

// File: logic/mmd_decoder.sv
// Code and data address space decoder of the embedded core
`timescale 1ns/1ps
`include "mmd_map.svh"

// Functional notes
// - With code space select low, code fetch and data read strobes are ORed to enable the internal 16 KB RAM.
// - The internal program/data RAM region holds only RAM, never control registers.
// - With code space select low the 16 KB RAM from zero is unified code and data memory.
// - External read and write strobes are suppressed for every address implemented on chip.
// - With code space select high the low 16 KB of code is fetched externally, RAM is data only.
// - Download, upload, setup pointer and boot loads reach only the 16 KB RAM and scratch RAM.
// - The control register window decodes E500 through E6FF of data space.
// - The waveform descriptor memory decodes E400 through E47F.
// - Three 64-byte small buffers sit at E740, E780 and E7C0.
// - Eight 512-byte large buffers form the 4 KB region F000 to FFFF.
// - The eight setup packet bytes live in a dedicated buffer at E6B8 to E6BF.
// - Endpoints 4 and 8 are double buffered only, endpoints 2 and 6 double, triple or quad.
// - Endpoint 0 is the only control endpoint and endpoint 1 is bulk or interrupt only.
// - Exactly one of 12 predefined large buffer layouts is accepted.
// - Full-speed bulk uses only the first 64 bytes of each 512-byte buffer.
// - Buffer space unused at full speed is not available for anything else.
module mmd_decoder (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_code_space_select,
	input  wire logic [15:0] i_addr,
	input  wire logic        i_code_fetch_strobe_n,
	input  wire logic        i_rd_strobe_n,
	input  wire logic        i_wr_strobe_n,
	input  wire logic        i_full_speed,
	input  wire logic        i_agent_req,
	input  wire logic [15:0] i_agent_addr,
	input  wire logic        i_cfg_wr,
	input  wire logic [3:0]  i_cfg_layout,
	input  wire logic [1:0]  i_cfg_ep1_type,
	input  wire logic        i_setup_wr,
	input  wire logic [2:0]  i_setup_idx,
	input  wire logic [7:0]  i_setup_data,
	output logic      [3:0]  o_region,
	output logic             o_int_ram_en,
	output logic             o_int_ram_we,
	output logic             o_ext_code_n,
	output logic             o_ext_rd_n,
	output logic             o_ext_wr_n,
	output logic      [7:0]  o_setup_rdata,
	output logic             o_setup_rvalid,
	output logic             o_agent_grant,
	output logic             o_agent_deny,
	output logic             o_cfg_err,
	output logic      [3:0]  o_layout,
	output logic      [11:0] o_depths,
	output logic      [1:0]  o_ep1_type,
	output logic      [9:0]  o_large_max_pkt
);

	localparam logic [143:0] LAYOUT_TABLE = `MMD_LAYOUT_TABLE;

	mmd_pkg::mmd_region_type region_reg;
	mmd_pkg::mmd_region_type region_next;
	logic        fetch;
	logic        rd;
	logic        wr;
	logic        access;
	logic        int_ram_en_reg;
	logic        int_ram_we_reg;
	logic        ext_code_n_reg;
	logic        ext_rd_n_reg;
	logic        ext_wr_n_reg;
	logic        setup_rvalid_reg;
	logic        agent_grant_reg;
	logic        agent_deny_reg;
	logic        agent_ok;
	logic        cfg_err_reg;
	logic        cfg_ok;
	logic [3:0]  layout_reg;
	logic [11:0] depths_reg;
	logic [1:0]  ep1_type_reg;
	logic [9:0]  large_max_pkt_reg;
	logic [11:0] layout_ok;
	logic [11:0] sel_entry;

	mmd_setup_if u_sif ();

	// Strobe qualifiers of the core bus
	assign fetch  = !i_code_fetch_strobe_n;
	assign rd     = !i_rd_strobe_n;
	assign wr     = !i_wr_strobe_n;
	assign access = fetch || rd || wr;

	// Address to target, code space first, then the data map
	function automatic mmd_pkg::mmd_region_type decode(
		input logic [15:0] a,
		input logic        code,
		input logic        ea,
		input logic        fs
	);
		mmd_pkg::mmd_region_type r;
		r = mmd_pkg::RG_RESERVED;
		if (code) begin
			if (!ea && (a <= `MMD_RAM_HI)) begin
				r = mmd_pkg::RG_MAIN_RAM;
			end else begin
				r = mmd_pkg::RG_EXTERNAL;
			end
		end else if (a <= `MMD_RAM_HI) begin
			r = mmd_pkg::RG_MAIN_RAM;
		end else if (a < `MMD_ONCHIP_LO) begin
			r = mmd_pkg::RG_EXTERNAL;
		end else if (a <= `MMD_SCR_HI) begin
			r = mmd_pkg::RG_SCRATCH;
		end else if ((a >= `MMD_WAVE_LO) && (a <= `MMD_WAVE_HI)) begin
			r = mmd_pkg::RG_WAVE;
		end else if ((a >= `MMD_SETUP_LO) && (a <= `MMD_SETUP_HI)) begin
			r = mmd_pkg::RG_SETUP;
		end else if ((a >= `MMD_REG_LO) && (a <= `MMD_REG_HI)) begin
			r = mmd_pkg::RG_REGS;
		end else if ((a >= `MMD_CTRL_LO) && (a <= `MMD_CTRL_HI)) begin
			r = mmd_pkg::RG_CTRL_BUF;
		end else if ((a >= `MMD_SOUT_LO) && (a <= `MMD_SOUT_HI)) begin
			r = mmd_pkg::RG_SMALL_OUT;
		end else if ((a >= `MMD_SIN_LO) && (a <= `MMD_SIN_HI)) begin
			r = mmd_pkg::RG_SMALL_IN;
		end else if (a >= `MMD_LARGE_LO) begin
			// Tail of each 512-byte block is dead at full speed
			if (fs && (a[8:0] >= `MMD_FS_OFS_LIM)) begin
				r = mmd_pkg::RG_RESERVED;
			end else begin
				r = mmd_pkg::RG_LARGE_BUF;
			end
		end
		return r;
	endfunction

	// Target of the current core access
	always_comb begin
		if (access) begin
			region_next = decode(i_addr, fetch, i_code_space_select, i_full_speed);
		end else begin
			region_next = mmd_pkg::RG_NONE;
		end
	end

	// Decoded target, held one cycle behind the address
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			region_reg <= mmd_pkg::RG_NONE;
		end else begin
			region_reg <= region_next;
		end
	end

	// Internal RAM enable from the fetch, read or write strobe
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			int_ram_en_reg <= 1'b0;
			int_ram_we_reg <= 1'b0;
		end else begin
			int_ram_en_reg <= (region_next == mmd_pkg::RG_MAIN_RAM) && (fetch || rd || wr);
			int_ram_we_reg <= (region_next == mmd_pkg::RG_MAIN_RAM) && wr;
		end
	end

	// External strobes pass only where no on-chip space exists
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ext_code_n_reg <= 1'b1;
			ext_rd_n_reg   <= 1'b1;
			ext_wr_n_reg   <= 1'b1;
		end else begin
			ext_code_n_reg <= !(fetch && (region_next == mmd_pkg::RG_EXTERNAL));
			// A data strobe beside a fetch never follows the code decode out of the chip
			ext_rd_n_reg   <= !(rd && !fetch && (region_next == mmd_pkg::RG_EXTERNAL));
			ext_wr_n_reg   <= !(wr && !fetch && (region_next == mmd_pkg::RG_EXTERNAL));
		end
	end

	// Setup packet store: written by the serial engine, read by the core
	assign u_sif.wr_en   = i_setup_wr;
	assign u_sif.wr_idx  = i_setup_idx;
	assign u_sif.wr_data = i_setup_data;
	assign u_sif.rd_en   = rd && (region_next == mmd_pkg::RG_SETUP);
	assign u_sif.rd_idx  = i_addr[2:0];

	mmd_setup_buf u_setup_buf (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.sif     (u_sif.mem)
	);

	// Read data valid pulse follows a setup read
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			setup_rvalid_reg <= 1'b0;
		end else begin
			setup_rvalid_reg <= u_sif.rd_en;
		end
	end

	// Loader agents reach only main RAM and scratch RAM
	assign agent_ok = (i_agent_addr <= `MMD_RAM_HI) ||
	                  ((i_agent_addr >= `MMD_SCR_LO) && (i_agent_addr <= `MMD_SCR_HI));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			agent_grant_reg <= 1'b0;
			agent_deny_reg  <= 1'b0;
		end else begin
			agent_grant_reg <= i_agent_req && agent_ok;
			agent_deny_reg  <= i_agent_req && !agent_ok;
		end
	end

	// Each table entry checked for legal buffering per endpoint
	genvar gl;
	generate
		for (gl = 0; gl < 12; gl++) begin : g_layout
			logic [2:0] d2;
			logic [2:0] d4;
			logic [2:0] d6;
			logic [2:0] d8;
			assign d2 = LAYOUT_TABLE[gl*12+9 +: 3];
			assign d4 = LAYOUT_TABLE[gl*12+6 +: 3];
			assign d6 = LAYOUT_TABLE[gl*12+3 +: 3];
			assign d8 = LAYOUT_TABLE[gl*12 +: 3];
			assign layout_ok[gl] = ((d4 == 3'h0) || (d4 == 3'h2)) &&
			                       ((d8 == 3'h0) || (d8 == 3'h2)) &&
			                       (d2 >= 3'h2) && (d2 <= 3'h4) &&
			                       (d6 >= 3'h2) && (d6 <= 3'h4);
		end
	endgenerate

	// Entry chosen by the configuration write
	always_comb begin
		sel_entry = 12'h000;
		if (i_cfg_layout < `MMD_LAYOUTS) begin
			sel_entry = LAYOUT_TABLE[i_cfg_layout*12 +: 12];
		end
	end

	// Whole configuration is taken or refused as one
	assign cfg_ok = (i_cfg_layout < `MMD_LAYOUTS) && layout_ok[i_cfg_layout] &&
	                ((i_cfg_ep1_type == `MMD_TYPE_BULK) || (i_cfg_ep1_type == `MMD_TYPE_INT));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			layout_reg   <= `MMD_LAYOUT_RST;
			depths_reg   <= LAYOUT_TABLE[11:0];
			ep1_type_reg <= `MMD_EP1_TYPE_RST;
		end else if (i_cfg_wr && cfg_ok) begin
			layout_reg   <= i_cfg_layout;
			depths_reg   <= sel_entry;
			ep1_type_reg <= i_cfg_ep1_type;
		end
	end

	// Refused configuration pulse
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_err_reg <= 1'b0;
		end else begin
			cfg_err_reg <= i_cfg_wr && !cfg_ok;
		end
	end

	// Packet limit of the large buffers by bus speed
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			large_max_pkt_reg <= `MMD_PKT_HS;
		end else begin
			large_max_pkt_reg <= i_full_speed ? `MMD_PKT_FS : `MMD_PKT_HS;
		end
	end

	// Outputs straight from flip-flops
	assign o_region        = region_reg;
	assign o_int_ram_en    = int_ram_en_reg;
	assign o_int_ram_we    = int_ram_we_reg;
	assign o_ext_code_n    = ext_code_n_reg;
	assign o_ext_rd_n      = ext_rd_n_reg;
	assign o_ext_wr_n      = ext_wr_n_reg;
	assign o_setup_rdata   = u_sif.rd_data;
	assign o_setup_rvalid  = setup_rvalid_reg;
	assign o_agent_grant   = agent_grant_reg;
	assign o_agent_deny    = agent_deny_reg;
	assign o_cfg_err       = cfg_err_reg;
	assign o_layout        = layout_reg;
	assign o_depths        = depths_reg;
	assign o_ep1_type      = ep1_type_reg;
	assign o_large_max_pkt = large_max_pkt_reg;

	// Checks on the decoded map
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	AST_RAM_OR: assert property (
		(!i_code_space_select && (fetch ^ rd) && !wr && (i_addr <= `MMD_RAM_HI))
		|=> (o_int_ram_en && !o_int_ram_we))
		else $error("internal RAM not enabled by a single read strobe");

	AST_NO_REGS_IN_RAM: assert property (
		(access && (i_addr <= `MMD_RAM_HI))
		|=> (o_region == 4'(mmd_pkg::RG_MAIN_RAM) || o_region == 4'(mmd_pkg::RG_EXTERNAL)))
		else $error("low 16 KB decoded as something other than RAM");

	AST_EA0_CODE: assert property (
		(!i_code_space_select && fetch && (i_addr <= `MMD_RAM_HI))
		|=> (o_ext_code_n && o_int_ram_en))
		else $error("internal code fetch went external");

	AST_EXT_ONLY_OFFCHIP: assert property (
		(!o_ext_rd_n || !o_ext_wr_n) |-> (o_region == 4'(mmd_pkg::RG_EXTERNAL)) &&
		($past(i_addr) > `MMD_RAM_HI) && ($past(i_addr) < `MMD_ONCHIP_LO))
		else $error("external data strobe on an on-chip address");

	AST_EA1_CODE: assert property (
		(i_code_space_select && fetch && !rd && !wr && (i_addr <= `MMD_RAM_HI))
		|=> (!o_ext_code_n && !o_int_ram_en && (o_region == 4'(mmd_pkg::RG_EXTERNAL))))
		else $error("low code fetch not external with select high");

	AST_AGENT_LIMIT: assert property (
		(i_agent_req && (i_agent_addr > `MMD_RAM_HI) && (i_agent_addr < `MMD_SCR_LO))
		|=> (o_agent_deny && !o_agent_grant))
		else $error("loader agent reached a forbidden address");

	AST_REG_WINDOW: assert property (
		(rd && !fetch && (i_addr >= `MMD_REG_LO) && (i_addr < `MMD_SETUP_LO))
		|=> (o_region == 4'(mmd_pkg::RG_REGS)) && o_ext_rd_n)
		else $error("register window not decoded");

	AST_WAVE: assert property (
		(rd && !fetch && (i_addr[15:7] == `MMD_WAVE_LO >> 7))
		|=> (o_region == 4'(mmd_pkg::RG_WAVE)))
		else $error("waveform memory not decoded");

	AST_SMALL_BUFS: assert property (
		(wr && !fetch && (i_addr == `MMD_SOUT_LO))
		|=> (o_region == 4'(mmd_pkg::RG_SMALL_OUT)) && o_ext_wr_n)
		else $error("small out buffer not decoded");

	AST_SETUP_READ: assert property (
		(rd && !fetch && (i_addr >= `MMD_SETUP_LO) && (i_addr <= `MMD_SETUP_HI))
		|=> (o_setup_rvalid && o_ext_rd_n && (o_region == 4'(mmd_pkg::RG_SETUP))))
		else $error("setup buffer read not answered");

	AST_LAYOUT_REFUSE: assert property (
		(i_cfg_wr && (i_cfg_layout >= `MMD_LAYOUTS))
		|=> (o_cfg_err && $stable(o_layout) && $stable(o_depths)))
		else $error("out of range layout accepted");

	AST_EP1_TYPE: assert property (
		o_ep1_type == `MMD_TYPE_BULK || o_ep1_type == `MMD_TYPE_INT)
		else $error("endpoint one holds an illegal type");

	AST_FS_TAIL: assert property (
		(i_full_speed && rd && !fetch && (i_addr >= `MMD_LARGE_LO) && (i_addr[8:0] >= `MMD_FS_OFS_LIM))
		|=> (o_region == 4'(mmd_pkg::RG_RESERVED)) && o_ext_rd_n && (o_large_max_pkt == `MMD_PKT_FS))
		else $error("full speed buffer tail reachable");

	COV_EXT_READ: cover property (rd && !o_ext_rd_n);
	COV_SETUP_READ: cover property (o_setup_rvalid);
	COV_CFG_TAKEN: cover property (i_cfg_wr && cfg_ok ##1 !o_cfg_err);
	COV_AGENT_DENY: cover property (o_agent_deny);

endmodule // mmd_decoder

// File: verification/mmd_ext_mem.sv
// External memory stand-in that counts cycles with an external strobe active
`timescale 1ns/1ps
module mmd_ext_mem (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_code_n,
	input  wire logic        i_rd_n,
	input  wire logic        i_wr_n,
	output logic      [15:0] o_hits
);
	// Count every cycle in which the decoder lets an external strobe through
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hits <= 16'h0000;
		end else if (!(i_code_n && i_rd_n && i_wr_n)) begin
			o_hits <= o_hits + 16'h0001;
		end
	end
endmodule // mmd_ext_mem

// File: verification/cpu_memory_map_decoder_test.sv
// Self-checking bench of the memory map decoder
`timescale 1ns/1ps
module cpu_memory_map_decoder_test;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ea = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic        fetch_n = 1'b1;
	logic        rd_n = 1'b1;
	logic        wr_n = 1'b1;
	logic        fs = 1'b0;
	logic        areq = 1'b0;
	logic [15:0] aaddr = 16'h0000;
	logic        cwr = 1'b0;
	logic [3:0]  clay = 4'h0;
	logic [1:0]  ctyp = 2'h2;
	logic        swr = 1'b0;
	logic [2:0]  sidx = 3'h0;
	logic [7:0]  sdat = 8'h00;
	logic [3:0]  region, lay;
	logic        ram_en, ram_we, x_code_n, x_rd_n, x_wr_n, srv, grant, deny, cerr;
	logic [7:0]  srd;
	logic [11:0] dep;
	logic [1:0]  typ;
	logic [9:0]  mpkt;
	logic [15:0] hits;
	int          err_count = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          n_ext = 0;

	// Clock at 40 MHz
	always #12.5 clk = ~clk;

	mmd_decoder i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_code_space_select(ea), .i_addr(addr),
		.i_code_fetch_strobe_n(fetch_n), .i_rd_strobe_n(rd_n), .i_wr_strobe_n(wr_n), .i_full_speed(fs),
		.i_agent_req(areq), .i_agent_addr(aaddr), .i_cfg_wr(cwr), .i_cfg_layout(clay),
		.i_cfg_ep1_type(ctyp), .i_setup_wr(swr), .i_setup_idx(sidx), .i_setup_data(sdat),
		.o_region(region), .o_int_ram_en(ram_en), .o_int_ram_we(ram_we), .o_ext_code_n(x_code_n),
		.o_ext_rd_n(x_rd_n), .o_ext_wr_n(x_wr_n), .o_setup_rdata(srd), .o_setup_rvalid(srv),
		.o_agent_grant(grant), .o_agent_deny(deny), .o_cfg_err(cerr), .o_layout(lay),
		.o_depths(dep), .o_ep1_type(typ), .o_large_max_pkt(mpkt));

	mmd_ext_mem i_mem (.i_clk(clk), .i_rst_n(rst_n), .i_code_n(x_code_n), .i_rd_n(x_rd_n),
		.i_wr_n(x_wr_n), .o_hits(hits));

	// Compare one result and count it
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// Verdict and end of run
	task automatic close_out();
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Hang guard, far above the fewer than two hundred cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			close_out();
		end
	end

	// One core cycle of kind 0 fetch, 1 read, 2 write; outputs settled on return
	task automatic drv(input int k, input logic [15:0] a);
		@(posedge clk);
		addr <= a;
		fetch_n <= (k != 0);
		rd_n <= (k != 1);
		wr_n <= (k != 2);
		@(posedge clk);
		fetch_n <= 1'b1;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		#1;
	endtask

	// Core access checked against the expected target region
	task automatic acc(input int k, input logic [15:0] a, input logic [3:0] r);
		logic ext;
		ext = (r == 4'ha);
		drv(k, a);
		if (ext) n_ext++;
		cmp("region", r, region);
		cmp("int_ram_en", r == 4'h1, ram_en);
		cmp("int_ram_we", r == 4'h1 && k == 2, ram_we);
		cmp("ext_code_n", !(ext && k == 0), x_code_n);
		cmp("ext_rd_n", !(ext && k == 1), x_rd_n);
		cmp("ext_wr_n", !(ext && k == 2), x_wr_n);
	endtask

	// Data map boundaries with internal code space
	task automatic t_map();
		logic [15:0] ma [24] = '{16'h0000, 16'h3fff, 16'h4000, 16'hdfff, 16'he000, 16'he1ff, 16'he200,
			16'he3ff, 16'he400, 16'he47f, 16'he480, 16'he500, 16'he6b7, 16'he6ff, 16'he700, 16'he740,
			16'he77f, 16'he780, 16'he7c0, 16'he7ff, 16'he800, 16'hefff, 16'hf000, 16'hffff};
		logic [3:0] mr [24] = '{1, 1, 10, 10, 2, 2, 11, 11, 3, 3, 11, 4, 4, 4, 11, 6, 6, 7, 8, 8, 11, 11, 9, 9};
		for (int i = 0; i < 24; i++) acc(1, ma[i], mr[i]);
		acc(0, 16'h0000, 4'h1);
		acc(0, 16'h3fff, 4'h1);
		acc(0, 16'h4000, 4'ha);
		acc(2, 16'h0000, 4'h1);
		acc(2, 16'h4000, 4'ha);
		acc(2, 16'he800, 4'hb);
		acc(2, 16'he780, 4'h7);
	endtask

	// External code space: low 16 KB fetched outside, RAM data only
	task automatic t_ea1();
		@(posedge clk) ea <= 1'b1;
		acc(0, 16'h0000, 4'ha);
		acc(0, 16'h3fff, 4'ha);
		acc(1, 16'h0000, 4'h1);
		acc(2, 16'h3fff, 4'h1);
		@(posedge clk) ea <= 1'b0;
	endtask

	// Full speed keeps only the first 64 bytes of each large buffer
	task automatic t_fs();
		@(posedge clk) fs <= 1'b1;
		acc(1, 16'hf03f, 4'h9);
		acc(1, 16'hf040, 4'hb);
		acc(1, 16'hf1ff, 4'hb);
		acc(1, 16'hf200, 4'h9);
		cmp("large_max_pkt", 10'h040, mpkt);
		@(posedge clk) fs <= 1'b0;
		@(posedge clk) #1;
		cmp("large_max_pkt", 10'h200, mpkt);
	endtask

	// Setup bytes written then read back at once, core write ignored
	task automatic t_setup();
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			swr <= 1'b1;
			sidx <= 3'(i);
			sdat <= 8'hc0 + 8'(i);
			@(posedge clk);
			swr <= 1'b0;
			addr <= 16'he6b8 + 16'(i);
			rd_n <= 1'b0;
			@(posedge clk);
			rd_n <= 1'b1;
			#1;
			cmp("setup_rvalid", 1'b1, srv);
			cmp("setup_rdata", 8'hc0 + 8'(i), srd);
			cmp("region", 4'h5, region);
			@(posedge clk) #1;
			cmp("setup_rvalid", 1'b0, srv);
		end
		drv(2, 16'he6bb);
		drv(1, 16'he6bb);
		cmp("setup_rdata", 8'hc3, srd);
	endtask

	// Loader access allowed only to main RAM and scratch RAM
	task automatic t_agent();
		logic [15:0] aa [8] = '{16'h0000, 16'h3fff, 16'h4000, 16'he000, 16'he1ff, 16'he200, 16'he500, 16'hf000};
		logic ok [8] = '{1, 1, 0, 1, 1, 0, 0, 0};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			areq <= 1'b1;
			aaddr <= aa[i];
			@(posedge clk);
			areq <= 1'b0;
			#1;
			cmp("agent_grant", ok[i], grant);
			cmp("agent_deny", !ok[i], deny);
		end
	endtask

	// One configuration write; refused writes keep the old setting
	task automatic cfg(input logic [3:0] l, input logic [1:0] t, input logic ok);
		logic [15:0] lt [12] = '{16'h2222, 16'h2022, 16'h2220, 16'h2020, 16'h3030, 16'h3022,
			16'h4022, 16'h4040, 16'h2040, 16'h2240, 16'h4020, 16'h3020};
		logic [3:0] pl;
		logic [11:0] pd;
		logic [1:0] pt;
		logic [15:0] d;
		pl = lay;
		pd = dep;
		pt = typ;
		d = lt[ok ? l : 4'h0];
		@(posedge clk);
		cwr <= 1'b1;
		clay <= l;
		ctyp <= t;
		@(posedge clk);
		cwr <= 1'b0;
		#1;
		cmp("cfg_err", !ok, cerr);
		cmp("layout", ok ? l : pl, lay);
		cmp("depths", ok ? {d[14:12], d[10:8], d[6:4], d[2:0]} : pd, dep);
		cmp("ep1_type", ok ? t : pt, typ);
		cmp("depth_legal", 1'b1, (dep[8:6] == 3'h2 || dep[8:6] == 3'h0) && (dep[2:0] == 3'h2 ||
			dep[2:0] == 3'h0) && dep[11:9] inside {[3'h2:3'h4]} && dep[5:3] inside {[3'h2:3'h4]});
	endtask

	// All layouts, then refused layouts and endpoint-one types
	task automatic t_cfg();
		for (int i = 0; i < 12; i++) cfg(4'(i), i[0] ? 2'h3 : 2'h2, 1'b1);
		cfg(4'hc, 2'h2, 1'b0);
		cfg(4'hf, 2'h3, 1'b0);
		cfg(4'h5, 2'h0, 1'b0);
		cfg(4'h5, 2'h1, 1'b0);
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		#1;
		cmp("layout", 4'h0, lay);
		cmp("depths", 12'h492, dep);
		cmp("ep1_type", 2'h2, typ);
		cmp("large_max_pkt", 10'h200, mpkt);
		@(posedge clk) rst_n <= 1'b1;
		t_map();
		t_ea1();
		t_fs();
		t_setup();
		t_agent();
		t_cfg();
		@(posedge clk) #1;
		cmp("ext_hits", 16'(n_ext), hits);
		close_out();
	end
endmodule // cpu_memory_map_decoder_test
